// file: logic/alert_cfg_pkg.sv
// constants, field layout and carrier types for the processor-hot alert configuration block
package alert_cfg_pkg;

	// register byte offsets, low byte first
	localparam logic [7:0] FIRST_OFFSET = 8'h36;
	localparam logic [7:0] SECOND_OFFSET = 8'h38;
	localparam logic [15:0] FIRST_RESET_MULTI = 16'h4A81;
	localparam logic [15:0] FIRST_RESET_SINGLE = 16'h4A09;
	localparam logic [15:0] SECOND_RESET = 16'h41A0;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // arbitrary bus address

	// field positions of alert_option_first
	localparam int OC_LSB = 11;
	localparam int OC_W = 5;
	localparam int CRIT_DEG_LSB = 9;
	localparam int DROOP_SEL_BIT = 8;
	localparam int RAIL_LSB = 2;
	localparam int RAIL_W = 6;
	localparam int NOM_DEG_BIT = 1;
	localparam int DROOP_LOWER_BIT = 0;

	// field positions of alert_option_second
	localparam int DIS_TH_LSB = 10;
	localparam int DIS_TH_W = 6;
	localparam int DIS_DEG_LSB = 8;
	localparam int PROF_COMP_BIT = 6;
	localparam int PROF_BAT_BIT = 1;

	// threshold decode figures
	localparam logic [8:0] OC_BASE_PCT = 9'h069;
	localparam logic [8:0] OC_STEP_PCT = 9'h005;
	localparam logic [4:0] OC_LOW_FIRST = 5'h01;
	localparam logic [4:0] OC_LOW_LAST = 5'h19;
	localparam logic [4:0] OC_HIGH_FIRST = 5'h1A;
	localparam logic [4:0] OC_HIGH_LAST = 5'h1E;
	localparam logic [8:0] OC_HIGH_BASE_PCT = 9'h0FA;
	localparam logic [8:0] OC_HIGH_STEP_PCT = 9'h032;
	localparam logic [12:0] CRIT_NUM = 13'h000B;
	localparam logic [12:0] CRIT_DEN = 13'h000A;
	localparam logic [6:0] DROOP_LOW_PCT = 7'h53;
	localparam logic [6:0] DROOP_HIGH_PCT = 7'h5B;
	localparam logic [6:0] DROOP_FULL_PCT = 7'h64;
	localparam logic [13:0] RAIL_BASE_MV = 14'h0C80;
	localparam logic [13:0] RAIL_STEP_MV = 14'h0064;
	localparam int SINGLE_RAIL_W = 3;
	localparam logic [15:0] DIS_STEP_MA = 16'h0200;

	// threshold values after reset
	localparam logic [8:0] OC_RESET_PCT = 9'h096;
	localparam logic [8:0] CRIT_RESET_PCT = 9'h0A5;
	localparam logic [13:0] RAIL_RESET_MV = 14'h1900;
	localparam logic [15:0] DIS_RESET_MA = 16'h2000;

	// timing, times in microseconds
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned T_CRIT_15US = 15;
	localparam int unsigned T_CRIT_100US = 100;
	localparam int unsigned T_CRIT_400US = 400;
	localparam int unsigned T_CRIT_800US = 800;
	localparam int unsigned T_RAIL_5US = 5;
	localparam int unsigned T_NOM_1MS = 1000;
	localparam int unsigned T_NOM_60MS = 60000;
	localparam int unsigned T_DIS_78MS = 78000;
	localparam int unsigned T_DIS_1250MS = 1250000;
	localparam int unsigned T_DIS_5S = 5000000;
	localparam int unsigned T_DIS_20S = 20000000;
	localparam int unsigned T_PULSE_US = 10;
	localparam int unsigned CRIT_15US_CYC = T_CRIT_15US * CLK_MHZ;
	localparam int unsigned RAIL_5US_CYC = T_RAIL_5US * CLK_MHZ;
	localparam int unsigned PULSE_CYC = T_PULSE_US * CLK_MHZ;
	localparam int CNT_W = 29;
	localparam int PULSE_W = 8;

	// analog trips and presence levels, all asynchronous
	typedef struct packed {
		logic droop_trip;
		logic comparator_trip;
		logic critical_trip;
		logic nominal_trip;
		logic discharge_trip;
		logic rail_low;
		logic battery_present;
		logic adapter_present;
	} trips_s;

	typedef struct packed {
		logic scl;
		logic sda;
		trips_s trips;
	} pins_s;

	// decoded thresholds handed to the analog side
	typedef struct packed {
		logic [8:0] overcurrent_pct;
		logic [8:0] critical_pct;
		logic [6:0] droop_pct;
		logic [13:0] rail_mv;
		logic [15:0] discharge_ma;
	} thresholds_s;

	typedef enum logic [3:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_REG, BUS_ACK_REG,
		BUS_WDATA, BUS_ACK_W, BUS_RDATA, BUS_ACK_R
	} bus_state_e;

endpackage

// file: logic/processor_hot_alert_config.sv
// processor-hot alert configuration registers, i2c slave and event qualification
// What this block does
// - overcurrent codes 1 to 25 decode to 110..230 percent in 5 percent steps.
// - codes 26 to 30 give 250..450 percent by 50; code 31 is ignored.
// - critical threshold is fixed at 110 percent of overcurrent threshold.
// - critical deglitch selects 15, 100, 400 or 800 us; resets to 100 us.
// - lowered droop threshold is 83 percent when select is 0, 91 when 1.
// - droop lower enable clear uses full regulation threshold; resets set.
// - multi-cell rail threshold is 3.2 V plus 100 mV per code; reset 6.4 V.
// - single-cell rail threshold uses the low three code bits; reset 3.4 V.
// - rail low held 5 us raises the input-bus discharge trigger.
// - nominal event deglitch is 1 ms when select is 0, 60 ms when 1.
// - a cleared profile bit hides its event from status and alert pin.
// - alert function is off when all profile and auxiliary enables are zero.
// - discharge threshold is code times 512 mA; reset 8192 mA.
// - discharge deglitch selects 78 ms, 1.25 s, 5 s or 20 s.
// - in low-power mode the comparator alert follows the low-power enable.
// - battery removal gives one alert pulse, also when enabled while absent.
// - single-cell rail codes differing only in upper bits give one threshold.
`timescale 1ns/10ps

module processor_hot_alert_config
#(
	parameter logic [6:0] DEV_ADDR = alert_cfg_pkg::DEV_ADDR_DEFAULT,
	parameter int unsigned CRIT_100US_CYC = alert_cfg_pkg::T_CRIT_100US * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned CRIT_400US_CYC = alert_cfg_pkg::T_CRIT_400US * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned CRIT_800US_CYC = alert_cfg_pkg::T_CRIT_800US * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned NOM_1MS_CYC = alert_cfg_pkg::T_NOM_1MS * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned NOM_60MS_CYC = alert_cfg_pkg::T_NOM_60MS * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned DIS_78MS_CYC = alert_cfg_pkg::T_DIS_78MS * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned DIS_1250MS_CYC = alert_cfg_pkg::T_DIS_1250MS * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned DIS_5S_CYC = alert_cfg_pkg::T_DIS_5S * alert_cfg_pkg::CLK_MHZ,
	parameter int unsigned DIS_20S_CYC = alert_cfg_pkg::T_DIS_20S * alert_cfg_pkg::CLK_MHZ
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire alert_cfg_pkg::trips_s trips_i,
	input wire logic single_cell_i,
	input wire logic low_power_mode_i,
	input wire logic low_power_alert_enable_i,
	input wire logic [1:0] alert_enable_aux_i,
	output alert_cfg_pkg::thresholds_s thresholds_o,
	output logic [7:0] alert_status_o,
	output logic processor_hot_alert_n_o,
	output logic rail_discharge_trigger_o
);
	import alert_cfg_pkg::*;

	typedef struct packed {
		pins_s s1;
		pins_s s2;
		pins_s s3;
		pins_s filt;
		logic [15:0] alert_option_first;
		logic [15:0] alert_option_second;
		logic strap_done;
		logic single;
		bus_state_e bus;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic sda_oe_n;
		logic sda_out;
		logic [3:0][CNT_W-1:0] cnt;
		logic [3:0] qual;
		logic [PULSE_W-1:0] pulse_cnt;
		logic prev_bat;
		logic prev_bat_en;
		thresholds_s thr;
		logic [7:0] status;
		logic alert_n;
		logic rail_trigger;
	} state_s;

	localparam int PIN_W = $bits(pins_s);
	// pins at rest: bus high, no trips, battery and adapter present; avoids false events after reset
	localparam pins_s PINS_IDLE = pins_s'(10'h303);

	state_s s;
	state_s next_s;

	// register byte seen by a bus read; unmapped bytes read as zero
	function automatic logic [7:0] byte_at(input logic [7:0] a, input logic [15:0] r0,
		input logic [15:0] r1);
		logic [7:0] b;
		b = 8'h00;
		if (a == FIRST_OFFSET)
			b = r0[7:0];
		else if (a == FIRST_OFFSET + 8'h01)
			b = r0[15:8];
		else if (a == SECOND_OFFSET)
			b = r1[7:0];
		else if (a == SECOND_OFFSET + 8'h01)
			b = r1[15:8];
		return b;
	endfunction

	always_comb
	begin
		state_s n;
		logic [PIN_W-1:0] agree;
		logic scl_rise;
		logic scl_fall;
		logic start_seen;
		logic stop_seen;
		logic [7:0] rd;
		logic [3:0][CNT_W-1:0] lim;
		logic [3:0] trig;
		logic [4:0] oc_code;
		logic [5:0] rail_code;
		logic [12:0] crit_wide;
		logic [7:0] events;
		logic [7:0] enables;
		logic func_en;
		logic bat_en;
		n = s;
		agree = '0;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_seen = 1'b0;
		stop_seen = 1'b0;
		rd = 8'h00;
		lim = '0;
		trig = '0;
		oc_code = '0;
		rail_code = '0;
		crit_wide = '0;
		events = '0;
		enables = '0;
		func_en = 1'b0;
		bat_en = 1'b0;

		// three-stage synchronisers; a change counts once stages two and three agree
		n.s1 = pins_s'({scl_i, sda_i, trips_i});
		n.s2 = s.s1;
		n.s3 = s.s2;
		agree = ~(s.s2 ^ s.s3);
		n.filt = pins_s'((s.filt & ~agree) | (s.s3 & agree));

		// cell count is caught on the first edge after reset release
		if (!s.strap_done)
		begin
			n.strap_done = 1'b1;
			n.single = single_cell_i;
			if (single_cell_i)
				n.alert_option_first = FIRST_RESET_SINGLE;
		end

		// i2c bus edges on the filtered lines
		scl_rise = n.filt.scl & ~s.filt.scl;
		scl_fall = ~n.filt.scl & s.filt.scl;
		start_seen = s.filt.scl & n.filt.scl & s.filt.sda & ~n.filt.sda;
		stop_seen = s.filt.scl & n.filt.scl & ~s.filt.sda & n.filt.sda;
		rd = byte_at(s.ptr, s.alert_option_first, s.alert_option_second);

		// i2c slave: byte pointer with auto-increment, sda changes only after scl falls
		if (start_seen)
		begin
			n.bus = BUS_ADDR;
			n.bitcnt = 4'h0;
			n.sda_oe_n = 1'b1;
		end
		else if (stop_seen)
		begin
			n.bus = BUS_IDLE;
			n.sda_oe_n = 1'b1;
		end
		else if (scl_rise)
		begin
			case (s.bus)
				BUS_ADDR, BUS_REG, BUS_WDATA:
				begin
					n.shift = {s.shift[6:0], n.filt.sda};
					n.bitcnt = s.bitcnt + 4'h1;
				end
				BUS_ACK_R:
				begin
					if (n.filt.sda)
						n.bus = BUS_IDLE; // master nack ends the read
				end
				default:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			case (s.bus)
				BUS_ADDR:
				begin
					if (s.bitcnt == 4'h8)
					begin
						if (s.shift[7:1] == DEV_ADDR)
						begin
							n.rw = s.shift[0];
							n.sda_oe_n = 1'b0;
							n.bus = BUS_ACK_ADDR;
						end
						else
							n.bus = BUS_IDLE;
					end
				end
				BUS_REG:
				begin
					if (s.bitcnt == 4'h8)
					begin
						n.ptr = s.shift;
						n.sda_oe_n = 1'b0;
						n.bus = BUS_ACK_REG;
					end
				end
				BUS_WDATA:
				begin
					if (s.bitcnt == 4'h8)
					begin
						if (s.ptr == FIRST_OFFSET)
							n.alert_option_first[7:0] = s.shift;
						else if (s.ptr == FIRST_OFFSET + 8'h01)
							n.alert_option_first[15:8] = s.shift;
						else if (s.ptr == SECOND_OFFSET)
							n.alert_option_second[7:0] = s.shift;
						else if (s.ptr == SECOND_OFFSET + 8'h01)
							n.alert_option_second[15:8] = s.shift;
						n.ptr = s.ptr + 8'h01;
						n.sda_oe_n = 1'b0;
						n.bus = BUS_ACK_W;
					end
				end
				BUS_ACK_ADDR, BUS_ACK_R:
				begin
					n.bitcnt = 4'h0;
					if (s.bus == BUS_ACK_R || s.rw)
					begin
						n.shift = rd;
						n.ptr = s.ptr + 8'h01;
						n.sda_oe_n = rd[7];
						n.bus = BUS_RDATA;
					end
					else
					begin
						n.sda_oe_n = 1'b1;
						n.bus = BUS_REG;
					end
				end
				BUS_ACK_REG, BUS_ACK_W:
				begin
					n.bitcnt = 4'h0;
					n.sda_oe_n = 1'b1;
					n.bus = BUS_WDATA;
				end
				BUS_RDATA:
				begin
					if (s.bitcnt == 4'h7)
					begin
						n.sda_oe_n = 1'b1;
						n.bus = BUS_ACK_R;
					end
					else
					begin
						n.bitcnt = s.bitcnt + 4'h1;
						n.shift = {s.shift[6:0], 1'b0};
						n.sda_oe_n = s.shift[6];
					end
				end
				default:
				begin
				end
			endcase
		end
		n.sda_out = 1'b0;

		// qualification times: three picked from the deglitch fields, the rail time fixed at 5 us
		case (s.alert_option_first[CRIT_DEG_LSB +: 2])
			2'h0: lim[0] = CNT_W'(CRIT_15US_CYC);
			2'h1: lim[0] = CNT_W'(CRIT_100US_CYC);
			2'h2: lim[0] = CNT_W'(CRIT_400US_CYC);
			default: lim[0] = CNT_W'(CRIT_800US_CYC);
		endcase
		lim[1] = s.alert_option_first[NOM_DEG_BIT] ? CNT_W'(NOM_60MS_CYC)
			: CNT_W'(NOM_1MS_CYC);
		case (s.alert_option_second[DIS_DEG_LSB +: 2])
			2'h0: lim[2] = CNT_W'(DIS_78MS_CYC);
			2'h1: lim[2] = CNT_W'(DIS_1250MS_CYC);
			2'h2: lim[2] = CNT_W'(DIS_5S_CYC);
			default: lim[2] = CNT_W'(DIS_20S_CYC);
		endcase
		lim[3] = CNT_W'(RAIL_5US_CYC);
		trig = {s.filt.trips.rail_low, s.filt.trips.discharge_trip,
			s.filt.trips.nominal_trip, s.filt.trips.critical_trip};

		// deglitch counters; any dropout restarts the full wait
		for (int i = 0; i < 4; i++)
		begin
			if (!trig[i])
			begin
				n.cnt[i] = '0;
				n.qual[i] = 1'b0;
			end
			else if (s.cnt[i] >= lim[i] - CNT_W'(1))
				n.qual[i] = 1'b1;
			else
				n.cnt[i] = s.cnt[i] + CNT_W'(1);
		end
		n.rail_trigger = s.qual[3];

		// battery removal one-shot, also fired when enabled while already absent
		bat_en = s.alert_option_second[PROF_BAT_BIT];
		n.prev_bat = s.filt.trips.battery_present;
		n.prev_bat_en = bat_en;
		if (bat_en && !s.filt.trips.battery_present && (s.prev_bat || !s.prev_bat_en))
			n.pulse_cnt = PULSE_W'(PULSE_CYC);
		else if (s.pulse_cnt != '0)
			n.pulse_cnt = s.pulse_cnt - PULSE_W'(1);

		// events gated by their profile bits onto status and the alert pin
		events = {s.filt.trips.droop_trip, s.filt.trips.comparator_trip, s.qual[0], s.qual[1],
			s.qual[2], s.qual[3], s.pulse_cnt != '0, ~s.filt.trips.adapter_present};
		enables = s.alert_option_second[7:0];
		if (low_power_mode_i)
			enables[PROF_COMP_BIT] = low_power_alert_enable_i;
		func_en = (|s.alert_option_second[7:0]) | (|alert_enable_aux_i);
		n.status = func_en ? (events & enables) : 8'h00;
		n.alert_n = ~(func_en & |(events & enables));

		// overcurrent decode; an out-of-range code keeps the last threshold
		oc_code = s.alert_option_first[OC_LSB +: OC_W];
		if (oc_code >= OC_LOW_FIRST && oc_code <= OC_LOW_LAST)
			n.thr.overcurrent_pct = OC_BASE_PCT + OC_STEP_PCT * 9'(oc_code);
		else if (oc_code >= OC_HIGH_FIRST && oc_code <= OC_HIGH_LAST)
			n.thr.overcurrent_pct = OC_HIGH_BASE_PCT
				+ OC_HIGH_STEP_PCT * 9'(oc_code - OC_HIGH_FIRST);
		crit_wide = (13'(s.thr.overcurrent_pct) * CRIT_NUM) / CRIT_DEN;
		n.thr.critical_pct = crit_wide[8:0];

		// droop comparator level
		if (s.alert_option_first[DROOP_LOWER_BIT])
			n.thr.droop_pct = s.alert_option_first[DROOP_SEL_BIT] ? DROOP_HIGH_PCT
				: DROOP_LOW_PCT;
		else
			n.thr.droop_pct = DROOP_FULL_PCT;

		// rail threshold; single cell ignores the upper code bits
		rail_code = s.alert_option_first[RAIL_LSB +: RAIL_W];
		if (s.single)
			rail_code = {3'h0, rail_code[SINGLE_RAIL_W-1:0]};
		n.thr.rail_mv = RAIL_BASE_MV + RAIL_STEP_MV * 14'(rail_code);

		n.thr.discharge_ma = DIS_STEP_MA
			* 16'(s.alert_option_second[DIS_TH_LSB +: DIS_TH_W]);
		next_s = n;
	end

	// single register stage; reset loads documented defaults
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.s1 <= PINS_IDLE;
			s.s2 <= PINS_IDLE;
			s.s3 <= PINS_IDLE;
			s.filt <= PINS_IDLE;
			s.alert_option_first <= FIRST_RESET_MULTI;
			s.alert_option_second <= SECOND_RESET;
			s.bus <= BUS_IDLE;
			s.sda_oe_n <= 1'b1;
			s.prev_bat <= 1'b1;
			s.thr.overcurrent_pct <= OC_RESET_PCT;
			s.thr.critical_pct <= CRIT_RESET_PCT;
			s.thr.droop_pct <= DROOP_LOW_PCT;
			s.thr.rail_mv <= RAIL_RESET_MV;
			s.thr.discharge_ma <= DIS_RESET_MA;
			s.alert_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign sda_o = s.sda_out;
	assign sda_oe_n_o = s.sda_oe_n;
	assign thresholds_o = s.thr;
	assign alert_status_o = s.status;
	assign processor_hot_alert_n_o = s.alert_n;
	assign rail_discharge_trigger_o = s.rail_trigger;

endmodule

// file: verification/alert_cfg_properties.sv
// port-level assertions for the alert configuration block
`timescale 1ns/10ps
module alert_cfg_properties
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire alert_cfg_pkg::trips_s trips_i,
	input wire alert_cfg_pkg::thresholds_s thresholds_o,
	input wire logic [7:0] alert_status_o,
	input wire logic processor_hot_alert_n_o,
	input wire logic rail_discharge_trigger_o
);
	import alert_cfg_pkg::*;
	logic [8:0] oc;
	logic [8:0] cr;
	// short aliases for the decoded current thresholds
	assign oc = thresholds_o.overcurrent_pct;
	assign cr = thresholds_o.critical_pct;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_reset_thresholds: assert property ($fell(rst_i) |-> oc == 9'h096 && cr == 9'h0A5
		&& thresholds_o.discharge_ma == 16'h2000) else $error("bad thresholds after reset");
	a_oc_legal: assert property ((oc >= 9'h06E && oc <= 9'h0E6 && oc % 5 == 0)
		|| (oc >= 9'h0FA && oc <= 9'h1C2 && oc % 50 == 0)) else $error("bad overcurrent");
	// critical trails by one clock, so wait for a settled overcurrent value
	a_crit_ratio: assert property ($stable(oc) [*3] |-> cr * 10 < oc * 11 + 10
		&& cr * 10 + 10 > oc * 11) else $error("critical not 110 percent");
	a_droop_legal: assert property (thresholds_o.droop_pct inside {7'h53, 7'h5B, 7'h64})
		else $error("bad droop threshold");
	a_rail_range: assert property (thresholds_o.rail_mv >= 14'h0C80
		&& thresholds_o.rail_mv <= 14'h251C && (thresholds_o.rail_mv - 14'h0C80) % 100 == 0)
		else $error("bad rail threshold");
	a_dis_step: assert property (thresholds_o.discharge_ma[8:0] == 9'h000
		&& thresholds_o.discharge_ma <= 16'h7E00) else $error("bad discharge threshold");
	a_rail_qual: assert property ($rose(rail_discharge_trigger_o) |-> $past(trips_i.rail_low, 120))
		else $error("rail trigger too early");
	a_rail_restart: assert property ((!trips_i.rail_low) [*8] |-> !rail_discharge_trigger_o)
		else $error("rail trigger outlived low rail");
	a_alert_status: assert property ((alert_status_o != 8'h00) == !processor_hot_alert_n_o)
		else $error("alert pin disagrees with status");
	a_battery_pulse: assert property ($rose(alert_status_o[1]) |-> !trips_i.battery_present)
		else $error("removal pulse with battery present");
	c_rail: cover property ($rose(rail_discharge_trigger_o));
	c_crit: cover property ($rose(alert_status_o[5]));
	c_bat: cover property ($rose(alert_status_o[1]));
endmodule

bind processor_hot_alert_config alert_cfg_properties chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.trips_i(trips_i),
	.thresholds_o(thresholds_o),
	.alert_status_o(alert_status_o),
	.processor_hot_alert_n_o(processor_hot_alert_n_o),
	.rail_discharge_trigger_o(rail_discharge_trigger_o)
);

// file: verification/i2c_host_model.sv
// behavioural i2c host that programs and reads the alert registers
`timescale 1ns/10ps
module i2c_host_model
#(
	parameter logic [6:0] ADDR = 7'h2A
)
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	logic ack_n;
	// phases of 10 clocks, five times the filter minimum
	task automatic hp(input int n = 10);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// data moves mid-low so the filter never sees it near a clock edge
	task automatic put_bit(input logic b);
		hp(5);
		sda_low_o = !b;
		hp();
		scl_o = 1'b1;
		hp();
		scl_o = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		hp(5);
		sda_low_o = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		b = sda_i;
		scl_o = 1'b0;
	endtask
	// serves as repeated start too
	task automatic start;
		hp(5);
		sda_low_o = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		sda_low_o = 1'b1;
		hp();
		scl_o = 1'b0;
	endtask
	task automatic stop;
		hp(5);
		sda_low_o = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		sda_low_o = 1'b0;
		hp();
	endtask
	task automatic put_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(ack_n);
	endtask
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
		start();
		put_byte({ADDR, 1'b0});
		put_byte(ptr);
		put_byte(d);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
		start();
		put_byte({ADDR, 1'b0});
		put_byte(ptr);
		start();
		put_byte({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(1'b1);
		stop();
	endtask
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
endmodule

// file: verification/processor_hot_alert_config_tb.sv
// self-checking bench for the alert configuration block
`timescale 1ns/10ps
module processor_hot_alert_config_tb;
	import alert_cfg_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl;
	logic sda_low;
	logic sda;
	logic sda_o;
	logic sda_oe_n;
	logic rail_trig;
	logic alert_n;
	logic [7:0] status;
	logic single_cell = 1'b0;
	logic low_power_mode = 1'b0;
	logic low_power_alert_en = 1'b0;
	logic [1:0] aux_en = 2'b00;
	trips_s trips;
	thresholds_s th;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	// pulled-up line, low when either side pulls
	assign sda = !(sda_low || !sda_oe_n);
	always #20 clk_i = ~clk_i;
	processor_hot_alert_config #(.CRIT_800US_CYC(40), .NOM_1MS_CYC(20),
		.DIS_1250MS_CYC(30)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n), .trips_i(trips), .single_cell_i(single_cell),
		.low_power_mode_i(low_power_mode), .low_power_alert_enable_i(low_power_alert_en),
		.alert_enable_aux_i(aux_en), .thresholds_o(th),
		.alert_status_o(status), .processor_hot_alert_n_o(alert_n),
		.rail_discharge_trigger_o(rail_trig));
	i2c_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	task automatic end_sim;
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// a run needs about 20k cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			end_sim();
		end
	end
	// reset values, then an unmapped byte that reads zero
	task automatic t_reset_values;
		logic [7:0] d;
		logic [7:0] exp [5] = '{8'h81, 8'h4A, 8'hA0, 8'h41, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			host.read_reg(8'h36 + 8'(i), d);
			check(d, exp[i]);
		end
		check(host.ack_n, 1'b0);
		check(sda_o, 1'b0);
	endtask
	// both code ranges and the ignored top code
	task automatic t_overcurrent;
		logic [4:0] code [5] = '{5'h01, 5'h19, 5'h1A, 5'h1E, 5'h1F};
		logic [8:0] pct [5] = '{9'h06E, 9'h0E6, 9'h0FA, 9'h1C2, 9'h1C2};
		for (int i = 0; i < 5; i++)
		begin
			host.write_reg(8'h37, {code[i], 3'b000});
			tick(4);
			check(th.overcurrent_pct, pct[i]);
		end
		check(th.critical_pct, 9'h1EF);
	endtask
	task automatic t_droop_rail;
		host.write_reg(8'h37, 8'hF1);
		tick(4);
		check(th.droop_pct, 7'h5B);
		host.write_reg(8'h36, 8'h80);
		tick(4);
		check(th.droop_pct, 7'h64);
		host.write_reg(8'h36, 8'hFD);
		host.write_reg(8'h39, 8'hFD);
		tick(4);
		check(th.rail_mv, 14'h251C);
		check(th.discharge_ma, 16'h7E00);
	endtask
	// a short gap must restart the rail deglitch
	task automatic t_rail;
		trips.rail_low = 1'b1;
		tick(100);
		trips.rail_low = 1'b0;
		tick(3);
		trips.rail_low = 1'b1;
		tick(120);
		check(rail_trig, 1'b0);
		tick(20);
		check(rail_trig, 1'b1);
		check(status, 8'h00);
		host.write_reg(8'h38, 8'hA4);
		tick(4);
		check({status, alert_n}, 9'h008);
		trips.rail_low = 1'b0;
		tick(10);
		check({rail_trig, alert_n}, 2'b01);
	endtask
	task automatic t_critical;
		logic [1:0] deg [2] = '{2'b00, 2'b11};
		int lim [2] = '{375, 40};
		for (int i = 0; i < 2; i++)
		begin
			host.write_reg(8'h37, {5'h1E, deg[i], 1'b0});
			trips.critical_trip = 1'b1;
			tick(lim[i] - 10);
			check(status[5], 1'b0);
			tick(20);
			check(status[5], 1'b1);
			trips.critical_trip = 1'b0;
			tick(10);
		end
	endtask
	// one pulse on removal, and again when enabled while absent
	task automatic t_battery;
		host.write_reg(8'h38, 8'hA6);
		trips.battery_present = 1'b0;
		tick(10);
		check({status[1], alert_n}, 2'b10);
		tick(300);
		check({status[1], alert_n}, 2'b01);
		host.write_reg(8'h38, 8'hA4);
		host.write_reg(8'h38, 8'hA6);
		tick(2);
		check(status[1], 1'b1);
	endtask
	// nominal and discharge deglitch, then function disable and low-power comparator enable
	task automatic t_options;
		host.write_reg(8'h38, 8'h18);
		trips.nominal_trip = 1'b1;
		trips.discharge_trip = 1'b1;
		tick(20);
		check(status[4:3], 2'b00);
		tick(12);
		check(status[4:3], 2'b10);
		tick(10);
		check(status[4:3], 2'b11);
		trips.nominal_trip = 1'b0;
		trips.discharge_trip = 1'b0;
		host.write_reg(8'h38, 8'h00);
		trips.comparator_trip = 1'b1;
		low_power_mode = 1'b1;
		low_power_alert_en = 1'b1;
		tick(10);
		check({status, alert_n}, 9'h001);
		aux_en = 2'b01;
		tick(2);
		check({status, alert_n}, 9'h080);
		low_power_mode = 1'b0;
		tick(2);
		check({status, alert_n}, 9'h001);
		trips.comparator_trip = 1'b0;
		aux_en = 2'b00;
	endtask
	// mid-run reset with the single-cell strap
	task automatic t_single;
		single_cell = 1'b1;
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		tick(4);
		check(th.rail_mv, 14'h0D48);
		host.write_reg(8'h36, 8'hED);
		tick(4);
		check(th.rail_mv, 14'h0DAC);
	endtask
	initial
	begin
		trips = '0;
		trips.battery_present = 1'b1;
		trips.adapter_present = 1'b1;
		tick(5);
		rst_i = 1'b0;
		tick(4);
		t_reset_values();
		t_overcurrent();
		t_droop_rail();
		t_rail();
		t_critical();
		t_battery();
		t_options();
		t_single();
		end_sim();
	end
endmodule
